// ==== hw/current_temp_limit_scaling.sv ====
`timescale 1ns/1ps
`include "current_temp_limit_scaling_map.svh"
// How it works
// - Correction factor clamped between 0.25 and 4.0
// - Invalid external reading falls back to die
// - Trims ignored while die temperature substitutes
// - Effective overcurrent fault threshold never negative
// - Effective reverse-current threshold always strictly negative
// - Readback returns last written word, unclamped
// - Tempco per page, uses page temperature
// - Tempco word is signed ppm per degree
// - Temperature is kelvin times gain, offset added
// - Gain trim unsigned, 0x4000 means unity
// - Four temperature limits supervised per page
// - Self-heating rise is read-only, paged
// - Rate word is inverse time constant
// - Thermal resistance word resets to zero
// - Offset trim paged linear word, default zero
// - Current thresholds scaled by gain, correction
module current_temp_limit_scaling #(
  parameter int PAGES = 4,
  parameter int PAGE_BITS = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [PAGE_BITS-1:0] cmd_page,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_rhit,
  // Measurement strobe and samples
  input wire logic meas_valid,
  input wire logic [PAGE_BITS-1:0] meas_page,
  input wire logic ext_valid,
  input wire logic [15:0] measured_kelvin_temp,
  input wire logic signed [15:0] die_temp,
  input wire logic signed [31:0] sense_voltage,
  input wire logic [15:0] sense_gain,
  input wire logic [15:0] power_watts,
  // Results
  output logic signed [15:0] reported_temp,
  output logic die_in_use,
  output logic [PAGES-1:0] overtemp_fault,
  output logic [PAGES-1:0] overtemp_warning,
  output logic [PAGES-1:0] undertemp_warning,
  output logic [PAGES-1:0] undertemp_fault,
  output logic [PAGES-1:0] overcurrent_fault,
  output logic [PAGES-1:0] overcurrent_warning,
  output logic [PAGES-1:0] reverse_current_fault
);
  localparam int REG_COUNT = 12;

  // ==========================================================
  // Helper functions
  // Linear word to fixed point with frac fractional bits
  function automatic scaling_pkg::fixed_type l11_decode(input logic [15:0] w, input logic [4:0] frac);
    logic signed [31:0] m;
    logic signed [6:0] s;
    m = 32'(signed'(w[`L11_MANT_MSB:0]));
    s = 7'(signed'(w[`L11_EXP_MSB:`L11_EXP_LSB])) + 7'(frac);
    // Cap the shift so later products cannot overflow 64 bits
    s = (s > `SHIFT_LIMIT) ? `SHIFT_LIMIT : s;
    l11_decode = (s >= 7'sh00) ? (m <<< s) : (m >>> (-s));
  endfunction

  // Command code to {hit, index}; the rise word is not stored here
  function automatic logic [4:0] cmd_index(input logic [7:0] c);
    case (c)
      `CMD_OC_FAULT: cmd_index = {1'b1, scaling_pkg::IDX_OC_FAULT};
      `CMD_OC_WARN: cmd_index = {1'b1, scaling_pkg::IDX_OC_WARN};
      `CMD_RC_FAULT: cmd_index = {1'b1, scaling_pkg::IDX_RC_FAULT};
      `CMD_TEMPCO: cmd_index = {1'b1, scaling_pkg::IDX_TEMPCO};
      `CMD_OT_FAULT: cmd_index = {1'b1, scaling_pkg::IDX_OT_FAULT};
      `CMD_OT_WARN: cmd_index = {1'b1, scaling_pkg::IDX_OT_WARN};
      `CMD_UT_WARN: cmd_index = {1'b1, scaling_pkg::IDX_UT_WARN};
      `CMD_UT_FAULT: cmd_index = {1'b1, scaling_pkg::IDX_UT_FAULT};
      `CMD_TAU_INV: cmd_index = {1'b1, scaling_pkg::IDX_TAU_INV};
      `CMD_THETA: cmd_index = {1'b1, scaling_pkg::IDX_THETA};
      `CMD_DGAIN: cmd_index = {1'b1, scaling_pkg::IDX_DGAIN};
      `CMD_DOFFSET: cmd_index = {1'b1, scaling_pkg::IDX_DOFFSET};
      default: cmd_index = 5'h00;
    endcase
  endfunction

  // Power-on word of each stored register
  function automatic logic [15:0] reset_word(input logic [3:0] i);
    case (i)
      scaling_pkg::IDX_OC_FAULT: reset_word = `RST_OC_FAULT;
      scaling_pkg::IDX_OC_WARN: reset_word = `RST_OC_WARN;
      scaling_pkg::IDX_RC_FAULT: reset_word = `RST_RC_FAULT;
      scaling_pkg::IDX_TEMPCO: reset_word = `RST_TEMPCO;
      scaling_pkg::IDX_OT_FAULT: reset_word = `RST_OT_FAULT;
      scaling_pkg::IDX_OT_WARN: reset_word = `RST_OT_WARN;
      scaling_pkg::IDX_UT_WARN: reset_word = `RST_UT_WARN;
      scaling_pkg::IDX_UT_FAULT: reset_word = `RST_UT_FAULT;
      scaling_pkg::IDX_TAU_INV: reset_word = `RST_TAU_INV;
      scaling_pkg::IDX_THETA: reset_word = `RST_THETA;
      scaling_pkg::IDX_DGAIN: reset_word = `RST_DGAIN;
      scaling_pkg::IDX_DOFFSET: reset_word = `RST_DOFFSET;
      default: reset_word = 16'h0000;
    endcase
  endfunction

  // Threshold in amps to sense volts: limit * gain * correction
  function automatic scaling_pkg::fixed_type scale_thr(input scaling_pkg::fixed_type th,
      input logic [15:0] g, input scaling_pkg::fixed_type tc);
    scale_thr = 32'((64'(th) * 64'($signed({1'b0, g})) * 64'(tc)) >>> `GAIN_FRAC);
  endfunction

  // ==========================================================
  // Storage
  logic [15:0] regs_reg [PAGES][REG_COUNT]; // Words exactly as written
  logic [10:0] rise_reg [PAGES]; // Self-heating rise, 1/16 degree
  logic [4:0] wr_sel; // Decoded write target
  logic [4:0] rd_sel; // Decoded read target
  assign wr_sel = cmd_index(cmd_code);
  assign rd_sel = cmd_index(cmd_code);

  // Host writes land in the addressed page; the rise word ignores them
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int p = 0; p < PAGES; p++)
      begin
        for (int i = 0; i < REG_COUNT; i++)
        begin
          regs_reg[p][i] <= reset_word(4'(i));
        end
      end
    end
    else if (cmd_wr && wr_sel[4])
    begin
      regs_reg[cmd_page][wr_sel[3:0]] <= cmd_wdata;
    end
  end

  // Readback is one cycle after the strobe; unmapped codes read zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_rdata <= 16'h0000;
      cmd_rvalid <= 1'b0;
      cmd_rhit <= 1'b0;
    end
    else
    begin
      cmd_rvalid <= cmd_rd;
      cmd_rhit <= cmd_rd && (rd_sel[4] || cmd_code == `CMD_SELF_HEAT);
      if (cmd_rd && rd_sel[4])
      begin
        cmd_rdata <= regs_reg[cmd_page][rd_sel[3:0]];
      end
      else if (cmd_rd && cmd_code == `CMD_SELF_HEAT)
      begin
        cmd_rdata <= {`SELF_HEAT_EXP, rise_reg[cmd_page]};
      end
      else if (cmd_rd)
      begin
        cmd_rdata <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // Measurement datapath for the strobed page
  scaling_pkg::fixed_type ext_temp_w; // Trimmed external temperature
  scaling_pkg::fixed_type temp_w; // Temperature in use
  scaling_pkg::fixed_type heat_w; // Stored rise of this page
  scaling_pkg::fixed_type dt_w; // Distance from 25 degrees
  scaling_pkg::fixed_type tc_val_w; // Signed ppm per degree
  scaling_pkg::fixed_type tcorr_w; // Clamped correction, Q14
  scaling_pkg::fixed_type oc_eff_w; // Effective overcurrent fault
  scaling_pkg::fixed_type rc_eff_w; // Effective reverse-current fault
  scaling_pkg::fixed_type theta_w; // Degrees per watt, 1/16
  scaling_pkg::fixed_type tau_w; // Rate, Q16
  scaling_pkg::fixed_type target_w; // Steady-state rise
  scaling_pkg::fixed_type rise_next; // Next rise before storing
  logic signed [63:0] tcorr_raw_w; // Correction before clamping

  // Kelvin times gain, minus 273.15, plus offset
  assign ext_temp_w = 32'((64'(measured_kelvin_temp) * 64'(regs_reg[meas_page][scaling_pkg::IDX_DGAIN]))
      >> `GAIN_FRAC) - `KELVIN_OFFSET_Q4
      + l11_decode(regs_reg[meas_page][scaling_pkg::IDX_DOFFSET], `TEMP_FRAC);
  // The die reading bypasses both trims when the sensor failed
  assign temp_w = ext_valid ? ext_temp_w : 32'(die_temp);
  assign heat_w = 32'(rise_reg[meas_page]);
  assign dt_w = temp_w + heat_w - `T_REF_Q4;
  assign tc_val_w = 32'(signed'(regs_reg[meas_page][scaling_pkg::IDX_TEMPCO]));
  // ppm scaling approximated by a multiply and shift to avoid a divider
  assign tcorr_raw_w = 64'(`TCORR_ONE) + ((64'(tc_val_w) * 64'(dt_w) * `PPM_MULT) >>> `PPM_SHIFT);

  // Correction is held inside its hardware window
  assign tcorr_w = (tcorr_raw_w < 64'(`TCORR_MIN)) ? `TCORR_MIN
      : (tcorr_raw_w > 64'(`TCORR_MAX)) ? `TCORR_MAX : 32'(tcorr_raw_w);

  // Effective copies; the written words stay untouched for readback
  always_comb
  begin
    oc_eff_w = l11_decode(regs_reg[meas_page][scaling_pkg::IDX_OC_FAULT], `TEMP_FRAC);
    rc_eff_w = l11_decode(regs_reg[meas_page][scaling_pkg::IDX_RC_FAULT], `TEMP_FRAC);
    if (oc_eff_w < 0)
    begin
      oc_eff_w = 32'sh0000_0000;
    end
    if (rc_eff_w >= 0)
    begin
      rc_eff_w = -32'sh0000_0001;
    end
  end

  // First-order rise model stepped once per sample of the page
  always_comb
  begin
    theta_w = l11_decode(regs_reg[meas_page][scaling_pkg::IDX_THETA], `TEMP_FRAC);
    tau_w = l11_decode(regs_reg[meas_page][scaling_pkg::IDX_TAU_INV], `RATE_FRAC);
    target_w = 32'((64'(theta_w) * 64'($signed({1'b0, power_watts}))) >>> `TEMP_FRAC);
    if (theta_w <= 0 || tau_w <= 0)
    begin
      rise_next = 32'sh0000_0000;
    end
    else if (tau_w >= `TCORR_MAX)
    begin
      rise_next = target_w;
    end
    else
    begin
      rise_next = heat_w + 32'((64'(target_w - heat_w) * 64'(tau_w)) >>> `RATE_FRAC);
    end
    if (rise_next < 0)
    begin
      rise_next = 32'sh0000_0000;
    end
    else if (rise_next > `SELF_HEAT_MAX)
    begin
      rise_next = `SELF_HEAT_MAX;
    end
  end

  // Self-heating state per page, starts at zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int p = 0; p < PAGES; p++)
      begin
        rise_reg[p] <= 11'h000;
      end
    end
    else if (meas_valid)
    begin
      rise_reg[meas_page] <= 11'(rise_next);
    end
  end

  // Supervision flags of the sampled page refresh on each strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reported_temp <= 16'sh0000;
      die_in_use <= 1'b0;
      overtemp_fault <= '0;
      overtemp_warning <= '0;
      undertemp_warning <= '0;
      undertemp_fault <= '0;
      overcurrent_fault <= '0;
      overcurrent_warning <= '0;
      reverse_current_fault <= '0;
    end
    else if (meas_valid)
    begin
      reported_temp <= 16'(temp_w);
      die_in_use <= !ext_valid;
      overtemp_fault[meas_page] <= temp_w >
          l11_decode(regs_reg[meas_page][scaling_pkg::IDX_OT_FAULT], `TEMP_FRAC);
      overtemp_warning[meas_page] <= temp_w >
          l11_decode(regs_reg[meas_page][scaling_pkg::IDX_OT_WARN], `TEMP_FRAC);
      undertemp_warning[meas_page] <= temp_w <
          l11_decode(regs_reg[meas_page][scaling_pkg::IDX_UT_WARN], `TEMP_FRAC);
      undertemp_fault[meas_page] <= temp_w <
          l11_decode(regs_reg[meas_page][scaling_pkg::IDX_UT_FAULT], `TEMP_FRAC);
      overcurrent_fault[meas_page] <= sense_voltage > scale_thr(oc_eff_w, sense_gain, tcorr_w);
      overcurrent_warning[meas_page] <= sense_voltage > scale_thr(
          l11_decode(regs_reg[meas_page][scaling_pkg::IDX_OC_WARN], `TEMP_FRAC), sense_gain, tcorr_w);
      reverse_current_fault[meas_page] <= sense_voltage < scale_thr(rc_eff_w, sense_gain, tcorr_w);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  tcorr_window_a: assert property (tcorr_w >= `TCORR_MIN && tcorr_w <= `TCORR_MAX)
    else $error("correction factor outside window");
  die_select_a: assert property (meas_valid |=> die_in_use == !$past(ext_valid))
    else $error("die substitution flag wrong");
  trim_bypass_a: assert property (meas_valid && !ext_valid |=> reported_temp == $past(die_temp))
    else $error("trims affected substituted temperature");
  oc_floor_a: assert property (oc_eff_w >= 0)
    else $error("overcurrent threshold negative");
  rc_negative_a: assert property (rc_eff_w < 0)
    else $error("reverse-current threshold not negative");
  write_readback_a: assert property ((cmd_wr && cmd_index(cmd_code) != 5'h00) ##1
      (cmd_rd && !cmd_wr && cmd_code == $past(cmd_code) && cmd_page == $past(cmd_page))
      |=> cmd_rvalid && cmd_rdata == $past(cmd_wdata, 2))
    else $error("readback differs from written word");
  tempco_sign_a: assert property (tc_val_w < 0 && dt_w > 0 |-> tcorr_w <= `TCORR_ONE)
    else $error("negative tempco raised correction");
  unity_gain_a: assert property (meas_valid && ext_valid
      && regs_reg[meas_page][scaling_pkg::IDX_DGAIN] == `RST_DGAIN
      && regs_reg[meas_page][scaling_pkg::IDX_DOFFSET] == `RST_DOFFSET
      |=> reported_temp == 16'($past(32'(measured_kelvin_temp)) - `KELVIN_OFFSET_Q4))
    else $error("unity gain not applied");
  ot_fault_a: assert property (meas_valid && temp_w >
      l11_decode(regs_reg[meas_page][scaling_pkg::IDX_OT_FAULT], `TEMP_FRAC)
      |=> overtemp_fault[$past(meas_page)])
    else $error("overtemperature fault missed");
  rise_range_a: assert property (rise_reg[meas_page] <= 11'(`SELF_HEAT_MAX))
    else $error("self-heating rise out of range");
  rise_zero_a: assert property (meas_valid && theta_w <= 0 |=> rise_reg[$past(meas_page)] == 11'h000)
    else $error("rise not zero with zero resistance");

  substitute_c: cover property (meas_valid && !ext_valid);
  clamp_low_c: cover property (meas_valid && tcorr_raw_w < 64'(`TCORR_MIN));
  oc_trip_c: cover property (meas_valid ##1 overcurrent_fault != '0);
  readback_c: cover property (cmd_wr ##1 cmd_rd ##1 cmd_rvalid);
endmodule

// ==== common/current_temp_limit_scaling_map.svh ====
`ifndef CURRENT_TEMP_LIMIT_SCALING_MAP_SVH
`define CURRENT_TEMP_LIMIT_SCALING_MAP_SVH
// Command codes
`define CMD_OC_FAULT 8'h46
`define CMD_OC_WARN 8'h4A
`define CMD_RC_FAULT 8'h4B
`define CMD_TEMPCO 8'hF6
`define CMD_OT_FAULT 8'h4F
`define CMD_OT_WARN 8'h51
`define CMD_UT_WARN 8'h52
`define CMD_UT_FAULT 8'h53
`define CMD_SELF_HEAT 8'hB8
`define CMD_TAU_INV 8'hB9
`define CMD_THETA 8'hBA
`define CMD_DGAIN 8'hF8
`define CMD_DOFFSET 8'hF9
// Reset values
`define RST_OC_FAULT 16'hD280
`define RST_OC_WARN 16'hCA80
`define RST_RC_FAULT 16'hBE00
`define RST_TEMPCO 16'h0000
`define RST_OT_FAULT 16'hEA08
`define RST_OT_WARN 16'hE3C0
`define RST_UT_WARN 16'h8000
`define RST_UT_FAULT 16'hCD80
`define RST_TAU_INV 16'h8000
`define RST_THETA 16'h8000
`define RST_DGAIN 16'h4000
`define RST_DOFFSET 16'h8000
// Field positions of the linear eleven-bit word
`define L11_EXP_MSB 15
`define L11_EXP_LSB 11
`define L11_MANT_MSB 10
// Fixed-point scaling, temperatures in 1/16 degree
`define TEMP_FRAC 5'h04
`define RATE_FRAC 5'h10
`define GAIN_FRAC 14
`define KELVIN_OFFSET_Q4 32'sh0000_1112
`define T_REF_Q4 32'sh0000_0190
`define TCORR_ONE 32'sh0000_4000
`define TCORR_MIN 32'sh0000_1000
`define TCORR_MAX 32'sh0001_0000
`define PPM_MULT 64'sh0000_0000_0000_0432
`define PPM_SHIFT 20
`define SELF_HEAT_MAX 32'sh0000_0320
`define SELF_HEAT_EXP 5'h1C
`define SHIFT_LIMIT 7'sh0D
`endif

// ==== common/scaling_pkg.sv ====
package scaling_pkg;
  // Index of each stored word within a page
  typedef enum logic [3:0] {
    IDX_OC_FAULT, IDX_OC_WARN, IDX_RC_FAULT, IDX_TEMPCO,
    IDX_OT_FAULT, IDX_OT_WARN, IDX_UT_WARN, IDX_UT_FAULT,
    IDX_TAU_INV, IDX_THETA, IDX_DGAIN, IDX_DOFFSET
  } reg_index_type;
  // Internal signed fixed-point value
  typedef logic signed [31:0] fixed_type;
endpackage

// ==== verif/cmd_host_model.sv ====
`timescale 1ns/1ps
// ==================================================
// Management host model
// ==================================================
// Issues single word writes and reads on the command port
module cmd_host_model #(
  parameter int PAGE_BITS = 2
) (
  // Clock
  input wire logic clk,
  // Command port towards the block
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [PAGE_BITS-1:0] cmd_page,
  output logic [15:0] cmd_wdata,
  // Answer from the block
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_rhit
);
  // Bus idle from time zero
  initial
  begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_page = '0;
    cmd_wdata = 16'h0000;
  end

  // One word write; released code and data lines show inverted values so stale data never passes as valid
  task automatic write_word(input logic [7:0] code, input logic [PAGE_BITS-1:0] page, input logic [15:0] data);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= code;
    cmd_page <= page;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_code <= ~code;
    cmd_wdata <= ~data;
  endtask

  // One word read; answer is {hit, data}, waited for under a bound of four edges
  task automatic read_word(input logic [7:0] code, input logic [PAGE_BITS-1:0] page, output logic [16:0] answer);
    answer = 17'h1FFFF;
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_code <= code;
    cmd_page <= page;
    @(posedge clk);
    cmd_rd <= 1'b0;
    cmd_code <= ~code;
    for (int i = 0; i < 4; i++)
    begin
      #1;
      if (cmd_rvalid === 1'b1)
      begin
        answer = {cmd_rhit, cmd_rdata};
        break;
      end
      @(posedge clk);
    end
  endtask

  // Write, then read the same word at the very next edge; answer is {hit, data}
  task automatic write_read(input logic [7:0] code, input logic [PAGE_BITS-1:0] page, input logic [15:0] data,
    output logic [16:0] answer);
    answer = 17'h1FFFF;
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= code;
    cmd_page <= page;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b1;
    @(posedge clk);
    cmd_rd <= 1'b0;
    cmd_code <= ~code;
    cmd_wdata <= ~data;
    #1;
    if (cmd_rvalid === 1'b1)
    begin
      answer = {cmd_rhit, cmd_rdata};
    end
  endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
// ==================================================
// Testbench top
// ==================================================
module tb_top;
  // Clock, reset and sample inputs
  logic clk;
  logic rstn;
  logic meas_valid;
  logic [1:0] meas_page;
  logic ext_valid;
  logic [15:0] measured_kelvin_temp;
  logic signed [15:0] die_temp;
  logic signed [31:0] sense_voltage;
  logic [15:0] sense_gain;
  logic [15:0] power_watts;
  // Command port wires between host model and block
  logic cmd_wr;
  logic cmd_rd;
  logic [7:0] cmd_code;
  logic [1:0] cmd_page;
  logic [15:0] cmd_wdata;
  logic [15:0] cmd_rdata;
  logic cmd_rvalid;
  logic cmd_rhit;
  // Results
  logic signed [15:0] reported_temp;
  logic die_in_use;
  logic [3:0] ot_f, ot_w, ut_w, ut_f, oc_f, oc_w, rc_f;
  // Bookkeeping
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [16:0] ans;
  // Readable words with their values after reset
  localparam logic [7:0] RST_CODES [12] = '{8'h46, 8'h4A, 8'h4B, 8'hF6, 8'h4F, 8'h51, 8'h52, 8'h53,
    8'hB9, 8'hBA, 8'hF8, 8'hF9};
  localparam logic [15:0] RST_WORDS [12] = '{16'hD280, 16'hCA80, 16'hBE00, 16'h0000, 16'hEA08, 16'hE3C0,
    16'h8000, 16'hCD80, 16'h8000, 16'h8000, 16'h4000, 16'h8000};
  // Kelvin samples (1/16 K) for 67.9, 63.0 and -12.1 C after a 1.0 C offset, and flags {otf,otw,utw,utf}
  localparam logic [15:0] FLAG_KELVIN [3] = '{16'h1540, 16'h14F2, 16'h1040};
  localparam logic [3:0] FLAG_EXP [3] = '{4'hC, 4'h4, 4'h3};

  // ==================================================
  // Clock, timeout
  // ==================================================
  always #10 clk = ~clk;

  // Whole run needs well under a thousand cycles; the ceiling only catches a hang
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      summarize();
    end
  end

  // ==================================================
  // Instances
  // ==================================================
  cmd_host_model #(.PAGE_BITS(2)) u_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cmd_rhit(cmd_rhit));

  current_temp_limit_scaling #(.PAGES(4), .PAGE_BITS(2)) u_dut (.clk(clk), .rstn(rstn), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .cmd_rhit(cmd_rhit), .meas_valid(meas_valid), .meas_page(meas_page),
    .ext_valid(ext_valid), .measured_kelvin_temp(measured_kelvin_temp), .die_temp(die_temp),
    .sense_voltage(sense_voltage), .sense_gain(sense_gain), .power_watts(power_watts),
    .reported_temp(reported_temp), .die_in_use(die_in_use), .overtemp_fault(ot_f), .overtemp_warning(ot_w),
    .undertemp_warning(ut_w), .undertemp_fault(ut_f), .overcurrent_fault(oc_f), .overcurrent_warning(oc_w),
    .reverse_current_fault(rc_f));

  // ==================================================
  // Tasks
  // ==================================================
  // Compare and count
  task automatic check(input logic [16:0] seen, input logic [16:0] expected, input string what);
    check_count = check_count + 1;
    if (seen !== expected)
    begin
      errors = errors + 1;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expected);
    end
  endtask

  // One sample; outputs land on the taking edge and are read one edge later
  task automatic measure(input logic [1:0] page, input logic ev, input logic [15:0] kel,
    input logic signed [15:0] die, input logic signed [31:0] volt);
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_page <= page;
    ext_valid <= ev;
    measured_kelvin_temp <= kel;
    die_temp <= die;
    sense_voltage <= volt;
    @(posedge clk);
    meas_valid <= 1'b0;
    measured_kelvin_temp <= ~kel;
    sense_voltage <= ~volt;
    @(posedge clk);
    #1;
  endtask

  // Closing report
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==================================================
  // Main sequence
  // ==================================================
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    meas_valid = 1'b0;
    meas_page = 2'h0;
    ext_valid = 1'b0;
    measured_kelvin_temp = 16'h0000;
    die_temp = 16'h0000;
    sense_voltage = 32'h0000_0000;
    // Gain of 1 milliohm keeps 1 A equal to 1 mV at the sense pins
    sense_gain = 16'h0100;
    power_watts = 16'h0000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // Reset words, then unmapped and read-only codes
    for (int i = 0; i < 12; i++)
    begin
      u_host.read_word(RST_CODES[i], 2'h3, ans);
      check(ans, {1'b1, RST_WORDS[i]}, "reset word");
    end
    u_host.read_word(8'h00, 2'h0, ans);
    check(ans, 17'h00000, "unmapped read");
    u_host.write_word(8'hB8, 2'h0, 16'h1234);
    u_host.read_word(8'hB8, 2'h0, ans);
    check(ans, 17'h1E000, "self heat word");
    $display("test registers done");
    // Written words read back unclamped, tempco kept per page
    u_host.write_word(8'h46, 2'h1, 16'hBE00);
    u_host.write_word(8'h4B, 2'h1, 16'hBA00);
    u_host.write_word(8'hF6, 2'h2, 16'h7FFF);
    u_host.read_word(8'h46, 2'h1, ans);
    check(ans, 17'h1BE00, "oc fault readback");
    u_host.read_word(8'h4B, 2'h1, ans);
    check(ans, 17'h1BA00, "rc fault readback");
    u_host.read_word(8'hF6, 2'h2, ans);
    check(ans, 17'h17FFF, "tempco readback");
    u_host.read_word(8'hF6, 2'h0, ans);
    check(ans, 17'h10000, "tempco other page");
    // Page 1 at 300 K: -0.5 A then +0.5 A against clamped thresholds
    measure(2'h1, 1'b1, 16'h12C0, 16'sh0000, -32'sd2048);
    check({1'b0, reported_temp}, 17'd430, "temp at 300 K");
    check({16'h0, oc_f[1]}, 17'h0, "oc fault at -0.5 A");
    check({16'h0, rc_f[1]}, 17'h1, "rc fault at -0.5 A");
    measure(2'h1, 1'b1, 16'h12C0, 16'sh0000, 32'sd2048);
    check({16'h0, rc_f[1]}, 17'h0, "rc fault at +0.5 A");
    check({16'h0, oc_f[1]}, 17'h1, "oc fault at +0.5 A");
    $display("test current limits done");
    // Gain 2.0 and offset +1.0 C, then a failed external reading
    u_host.write_word(8'hF8, 2'h1, 16'h8000);
    u_host.write_word(8'hF9, 2'h1, 16'hBA00);
    measure(2'h1, 1'b1, 16'h12C0, 16'sh0000, 32'sd0);
    check({1'b0, reported_temp}, 17'd5246, "trimmed temp");
    measure(2'h1, 1'b0, 16'h12C0, 16'sd500, 32'sd0);
    check({1'b0, reported_temp}, 17'd500, "die substitute");
    check({16'h0, die_in_use}, 17'h1, "die in use");
    // Four limits at default values, offset still applied
    u_host.write_word(8'hF8, 2'h1, 16'h4000);
    for (int i = 0; i < 3; i++)
    begin
      measure(2'h1, 1'b1, FLAG_KELVIN[i], 16'sh0000, 32'sd0);
      check({13'h0, ot_f[1], ot_w[1], ut_w[1], ut_f[1]}, {13'h0, FLAG_EXP[i]}, "temp flags");
    end
    $display("test temperature done");
    // Page 2 at 125 C: correction factor runs past both ends; warning at 5 A scaled
    repeat (2) measure(2'h2, 1'b1, 16'h18E2, 16'sh0000, 32'sd84787);
    check({15'h0, oc_w[2], oc_f[2]}, 17'h2, "upper correction clamp");
    u_host.write_word(8'hF6, 2'h2, 16'h8000);
    repeat (2) measure(2'h2, 1'b1, 16'h18E2, 16'sh0000, 32'sd4915);
    check({16'h0, oc_w[2]}, 17'h0, "lower correction clamp");
    $display("test correction done");
    // Page 3 rise: 1 C/W at 10 W with rate 0.5, then rate 1.0 at 100 W, then zero resistance
    u_host.write_read(8'hBA, 2'h3, 16'hBA00, ans);
    check(ans, 17'h1BA00, "back to back readback");
    u_host.write_word(8'hB9, 2'h3, 16'hB900);
    @(posedge clk);
    power_watts <= 16'd160;
    measure(2'h3, 1'b1, 16'h12C0, 16'sh0000, 32'sd0);
    u_host.read_word(8'hB8, 2'h3, ans);
    check(ans, 17'h1E050, "rise after one step");
    measure(2'h3, 1'b1, 16'h12C0, 16'sh0000, 32'sd0);
    u_host.read_word(8'hB8, 2'h3, ans);
    check(ans, 17'h1E078, "rise after two steps");
    u_host.write_word(8'hB9, 2'h3, 16'hBA00);
    @(posedge clk);
    power_watts <= 16'd1600;
    measure(2'h3, 1'b1, 16'h12C0, 16'sh0000, 32'sd0);
    u_host.read_word(8'hB8, 2'h3, ans);
    check(ans, 17'h1E320, "rise held at 50 C");
    u_host.write_word(8'hBA, 2'h3, 16'h8000);
    measure(2'h3, 1'b1, 16'h12C0, 16'sh0000, 32'sd0);
    u_host.read_word(8'hB8, 2'h3, ans);
    check(ans, 17'h1E000, "rise with zero resistance");
    $display("test self heating done");
    // Doubled sense gain: 9 mV is under the 5 A warning at 2 milliohm
    @(posedge clk);
    sense_gain <= 16'h0200;
    measure(2'h1, 1'b1, 16'h12C0, 16'sh0000, 32'sd36864);
    check({16'h0, oc_w[1]}, 17'h0, "warning at doubled gain");
    $display("test sense gain done");
    summarize();
  end
endmodule
